//--- core/port_read_path_selftest.sv
// Notes on behaviour
// - Key byte 11001010 sets the read-back enable flag; reads then sample pins.
// - Any other key value clears the flag; output-pin reads return the data latch.
// - With read-back on, a data register read returns current pin levels.
// - Read-back changes only the read path, never drive or function select.
// - With read-back off, pins behave per their selected function unchanged.
// - Output pin (direction 0) reads latch when off, pin level when on.
// - Reset sets all data and direction bits high, so pins start as inputs.
// - Pins switched to output drive high until software writes the data latch.
// - Bit set/clear reads whole port, modifies one bit, writes whole byte back.
// - In sleep, a falling edge on an enabled Port A pin wakes the device.
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module port_read_path_selftest #(
    parameter int WIDTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic wake_req
);
    logic [7:0] key_q;
    logic [WIDTH-1:0] data_q;
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] wake_en_q;
    logic [WIDTH-1:0] wake_stat_q;
    logic sleep_q;
    logic [WIDTH-1:0] pin_meta_q;
    logic [WIDTH-1:0] pin_sync_q;
    logic [WIDTH-1:0] pin_prev_q;
    logic [7:0] awaddr_q;
    logic aw_have_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_have_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic rb_en;
    logic do_write;
    logic wr_lane0;
    logic [WIDTH-1:0] port_view;
    logic [WIDTH-1:0] fall;
    logic [31:0] rd_d;
    logic [1:0] rresp_d;

    // All checks below share this clock and are off during reset.
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Two stages on the pins because they come from outside the clock domain.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_meta_q <= '1;
            pin_sync_q <= '1;
            pin_prev_q <= '1;
        end
        else
        begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    assign rb_en = (key_q == port_rb_pkg::KEY_MATCH);

    // Latch or pin per direction.
    // Inputs always read the pin; outputs read the latch unless read-back.
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            if (dir_q[i] || rb_en)
            begin
                port_view[i] = pin_sync_q[i];
            end
            else
            begin
                port_view[i] = data_q[i];
            end
        end
    end

    // Pins follow latch and direction only, never the key.
    assign pin_out = data_q;
    assign pin_oe = ~dir_q;

    // Write channel capture; address and data may arrive in either order.
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign do_write = aw_have_q && w_have_q && !bvalid_q;
    assign wr_lane0 = wstrb_q[0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= port_rb_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                if (awaddr_q == port_rb_pkg::KEY_OFS ||
                    awaddr_q == port_rb_pkg::DATA_OFS ||
                    awaddr_q == port_rb_pkg::DIR_OFS ||
                    awaddr_q == port_rb_pkg::WAKE_EN_OFS ||
                    awaddr_q == port_rb_pkg::WAKE_STAT_OFS ||
                    awaddr_q == port_rb_pkg::MODE_OFS)
                begin
                    bresp_q <= port_rb_pkg::RESP_OKAY;
                end
                else
                begin
                    bresp_q <= port_rb_pkg::RESP_SLVERR;
                end
            end
            else if (bvalid_q && s_axi_bready)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Whole-byte writes carry the modified port.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            key_q <= port_rb_pkg::KEY_RST;
            data_q <= port_rb_pkg::DATA_RST[WIDTH-1:0];
            dir_q <= port_rb_pkg::DIR_RST[WIDTH-1:0];
            wake_en_q <= port_rb_pkg::WAKE_EN_RST[WIDTH-1:0];
        end
        else if (do_write && wr_lane0)
        begin
            if (awaddr_q == port_rb_pkg::KEY_OFS)
            begin
                key_q <= wdata_q[7:0];
            end
            else if (awaddr_q == port_rb_pkg::DATA_OFS)
            begin
                data_q <= wdata_q[WIDTH-1:0];
            end
            else if (awaddr_q == port_rb_pkg::DIR_OFS)
            begin
                dir_q <= wdata_q[WIDTH-1:0];
            end
            else if (awaddr_q == port_rb_pkg::WAKE_EN_OFS)
            begin
                wake_en_q <= wdata_q[WIDTH-1:0];
            end
        end
    end

    // Falling-edge wake detection.
    // Sleep is left by hardware on wake so software sees it cleared.
    assign fall = pin_prev_q & ~pin_sync_q & wake_en_q;
    assign wake_req = |wake_stat_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sleep_q <= 1'b0;
        end
        else if (sleep_q && (|fall))
        begin
            sleep_q <= 1'b0;
        end
        else if (do_write && wr_lane0 &&
                 awaddr_q == port_rb_pkg::MODE_OFS)
        begin
            sleep_q <= wdata_q[port_rb_pkg::MODE_SLEEP_BIT];
        end
    end

    // Write-one-to-clear status; a new edge in the same cycle wins.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wake_stat_q <= '0;
        end
        else
        begin
            for (int i = 0; i < WIDTH; i++)
            begin
                if (sleep_q && fall[i])
                begin
                    wake_stat_q[i] <= 1'b1;
                end
                else if (do_write && wr_lane0 &&
                         awaddr_q == port_rb_pkg::WAKE_STAT_OFS &&
                         wdata_q[i])
                begin
                    wake_stat_q[i] <= 1'b0;
                end
            end
        end
    end

    // Read decode.
    always_comb
    begin
        rd_d = 32'h0000_0000;
        rresp_d = port_rb_pkg::RESP_OKAY;
        if (s_axi_araddr == port_rb_pkg::KEY_OFS)
        begin
            rd_d[7:0] = key_q;
        end
        else if (s_axi_araddr == port_rb_pkg::DATA_OFS)
        begin
            rd_d[WIDTH-1:0] = port_view;
        end
        else if (s_axi_araddr == port_rb_pkg::DIR_OFS)
        begin
            rd_d[WIDTH-1:0] = dir_q;
        end
        else if (s_axi_araddr == port_rb_pkg::WAKE_EN_OFS)
        begin
            rd_d[WIDTH-1:0] = wake_en_q;
        end
        else if (s_axi_araddr == port_rb_pkg::WAKE_STAT_OFS)
        begin
            rd_d[WIDTH-1:0] = wake_stat_q;
        end
        else if (s_axi_araddr == port_rb_pkg::MODE_OFS)
        begin
            rd_d[port_rb_pkg::MODE_SLEEP_BIT] = sleep_q;
            rd_d[port_rb_pkg::MODE_RB_BIT] = rb_en;
        end
        else
        begin
            rresp_d = port_rb_pkg::RESP_SLVERR;
        end
    end

    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= port_rb_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_d;
            rresp_q <= rresp_d;
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Checks on the read path and pins.
    a_key_enable: assert property (
        (do_write && wr_lane0 && awaddr_q == port_rb_pkg::KEY_OFS &&
        wdata_q[7:0] == port_rb_pkg::KEY_MATCH) |=> rb_en)
        else $error("read-back not on after matching key");
    a_key_disable: assert property (
        (do_write && wr_lane0 && awaddr_q == port_rb_pkg::KEY_OFS &&
        wdata_q[7:0] != port_rb_pkg::KEY_MATCH) |=>
        !rb_en && port_view == ((pin_sync_q & dir_q) | (data_q & ~dir_q)))
        else $error("latch path not used when disabled");
    a_pin_view: assert property (
        (s_axi_arvalid && s_axi_arready && rb_en && s_axi_araddr == 8'h04)
        |=> rdata_q[WIDTH-1:0] == $past(pin_sync_q))
        else $error("read-back did not return pin levels");
    a_drive_stable: assert property (
        $changed(rb_en) |-> $stable(pin_out) && $stable(pin_oe))
        else $error("read-back changed pin drive");
    a_drive_follow: assert property (
        pin_oe == ~dir_q && pin_out == data_q)
        else $error("pin drive not from latch and direction");
    a_out_latch: assert property (
        (!rb_en && !dir_q[0]) |-> port_view[0] == data_q[0])
        else $error("output pin read not from latch");
    a_reset_high: assert property (
        $rose(aresetn) |-> data_q == '1 && dir_q == '1 && key_q == 8'h00)
        else $error("reset values wrong");
    a_drive_high: assert property (
        $rose(aresetn) |-> pin_out == '1)
        else $error("pins would not drive high after reset");
    a_byte_write: assert property (
        (do_write && wr_lane0 && awaddr_q == 8'h04) |=>
        data_q == $past(wdata_q[WIDTH-1:0]))
        else $error("whole byte not written back");
    a_wake_edge: assert property (
        (sleep_q && (|fall)) |=> !sleep_q && wake_req)
        else $error("falling edge did not wake");
    a_key_rw: assert property (
        (do_write && wr_lane0 && awaddr_q == 8'h00) |=>
        key_q == $past(wdata_q[7:0]))
        else $error("key register not written");

    c_enable: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(rb_en));
    c_pin_read: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && rb_en);
    c_wake: cover property (@(posedge aclk) disable iff (!aresetn)
        $fell(sleep_q) && wake_req);
endmodule
`default_nettype wire

//--- core/port_rb_pkg.sv
package port_rb_pkg;
    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] KEY_OFS = 8'h00;
    localparam logic [7:0] DATA_OFS = 8'h04;
    localparam logic [7:0] DIR_OFS = 8'h08;
    localparam logic [7:0] WAKE_EN_OFS = 8'h0c;
    localparam logic [7:0] WAKE_STAT_OFS = 8'h10;
    localparam logic [7:0] MODE_OFS = 8'h14;
    // Reset values.
    localparam logic [7:0] KEY_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'hff;
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [7:0] WAKE_EN_RST = 8'h00;
    // Pattern that turns on pin read-back.
    localparam logic [7:0] KEY_MATCH = 8'hca;
    // Field positions in the mode register.
    localparam int MODE_SLEEP_BIT = 0;
    localparam int MODE_RB_BIT = 1;
    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

//--- tb/pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// Board side of the port: a pad follows its driver while enabled and the
// board level otherwise; the short mask fakes a pad stuck at board level.
module pin_model (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] board_level,
    input wire logic [7:0] short_mask,
    output logic [7:0] pin_level
);
    // A shorted pad wins over the driver, so latch and pad can differ.
    assign pin_level = (pin_oe & ~short_mask & pin_out)
        | ((~pin_oe | short_mask) & board_level);
endmodule
`default_nettype wire

//--- tb/port_read_path_selftest_tb.sv
`timescale 1ns/1ns
`default_nettype none
module port_read_path_selftest_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic [7:0] pin_level, pin_out, pin_oe, board, short_mask;
    logic wake_req;
    logic [31:0] d;
    logic [1:0] r;
    int n_fail = 0;
    int n_tests = 0;

    initial board = 8'h3c;
    initial short_mask = 8'h00;

    port_read_path_selftest i_port_read_path_selftest (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pin_in(pin_level), .pin_out(pin_out), .pin_oe(pin_oe),
        .wake_req(wake_req));

    pin_model i_pin_model (.pin_out(pin_out), .pin_oe(pin_oe),
        .board_level(board), .short_mask(short_mask),
        .pin_level(pin_level));

    // Free-running 100 MHz clock.
    initial
    begin
        forever #5 aclk = ~aclk;
    end

    // Write one word; each channel is dropped only once it is taken.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        // One idle edge, so a following call never re-raises bready at once.
        @(posedge aclk);
    endtask

    // Read one word; data and response are taken at the rvalid edge.
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        // One idle edge, so a following call never re-raises rready at once.
        @(posedge aclk);
    endtask

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic t_reset();
        rd(port_rb_pkg::KEY_OFS);
        chk("key", 32'h0, d);
        rd(port_rb_pkg::DIR_OFS);
        chk("dir", 32'hff, d);
        chk("oe", 32'h0, {24'h0, pin_oe});
        rd(port_rb_pkg::DATA_OFS);
        chk("input view", 32'h3c, d);
        $display("test reset done");
    endtask

    task automatic t_out_default();
        wr(port_rb_pkg::DIR_OFS, 8'h00);
        chk("oe", 32'hff, {24'h0, pin_oe});
        chk("out", 32'hff, {24'h0, pin_out});
        $display("test output default done");
    endtask

    task automatic t_readback();
        wr(port_rb_pkg::DATA_OFS, 8'h5a);
        short_mask <= 8'hff;
        board <= 8'ha5;
        rd(port_rb_pkg::DATA_OFS);
        chk("latch view", 32'h5a, d);
        wr(port_rb_pkg::KEY_OFS, 8'hca);
        rd(port_rb_pkg::KEY_OFS);
        chk("key", 32'hca, d);
        rd(port_rb_pkg::MODE_OFS);
        chk("flag on", 32'h2, d);
        rd(port_rb_pkg::DATA_OFS);
        chk("pin view", 32'ha5, d);
        chk("out kept", 32'h5a, {24'h0, pin_out});
        chk("oe kept", 32'hff, {24'h0, pin_oe});
        wr(port_rb_pkg::KEY_OFS, 8'hcb);
        rd(port_rb_pkg::MODE_OFS);
        chk("flag off", 32'h0, d);
        rd(port_rb_pkg::DATA_OFS);
        chk("latch again", 32'h5a, d);
        short_mask <= 8'h00;
        $display("test read-back done");
    endtask

    task automatic t_rmw();
        rd(port_rb_pkg::DATA_OFS);
        wr(port_rb_pkg::DATA_OFS, d[7:0] | 8'h80);
        chk("bit set", 32'hda, {24'h0, pin_out});
        $display("test bit set done");
    endtask

    task automatic t_wake();
        wr(port_rb_pkg::DIR_OFS, 8'hff);
        board <= 8'hff;
        wr(port_rb_pkg::WAKE_EN_OFS, 8'h01);
        wr(port_rb_pkg::MODE_OFS, 8'h01);
        board <= 8'hfd;
        repeat (8) @(posedge aclk);
        chk("masked edge", 32'h0, {31'h0, wake_req});
        board <= 8'hfc;
        repeat (8) @(posedge aclk);
        chk("wake", 32'h1, {31'h0, wake_req});
        rd(port_rb_pkg::MODE_OFS);
        chk("sleep cleared", 32'h0, d);
        wr(port_rb_pkg::WAKE_STAT_OFS, 8'h01);
        rd(port_rb_pkg::WAKE_STAT_OFS);
        chk("status", 32'h0, d);
        $display("test wake done");
    endtask

    task automatic t_unmapped();
        wr(8'h40, 8'h12);
        chk("wr resp", {30'h0, port_rb_pkg::RESP_SLVERR}, {30'h0, r});
        rd(8'h40);
        chk("rd resp", {30'h0, port_rb_pkg::RESP_SLVERR}, {30'h0, r});
        // A write without byte lane 0 is answered but leaves the latch alone.
        wstrb <= 4'he;
        wr(port_rb_pkg::DATA_OFS, 8'h00);
        wstrb <= 4'hf;
        chk("strobe resp", {30'h0, port_rb_pkg::RESP_OKAY}, {30'h0, r});
        chk("strobe off", 32'hda, {24'h0, pin_out});
        $display("test unmapped done");
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence: reset for four cycles, then each scenario in turn.
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_out_default();
        t_readback();
        t_rmw();
        t_wake();
        t_unmapped();
        test_done();
    end

    // The whole run needs well under a thousand cycles.
    initial
    begin
        repeat (5000) @(posedge aclk);
        n_fail++;
        test_done();
    end
endmodule
`default_nettype wire
